// File: hdl/icw_ctrl.sv
// Command word decoder, mask and in-service logic of one controller
`timescale 1ns/1ps
`default_nettype none
module icw_ctrl
   import icw_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_cs,
   input  wire logic       i_a0,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_data,
   input  wire logic       i_ack,
   input  wire logic [7:0] i_req,
   output logic      [7:0] o_data,
   output logic            o_int,
   output logic      [7:0] o_vector,
   output logic      [7:0] o_in_service
);

   localparam int PIN_W = 11;

   // Three-stage pin synchronisers with agreement filter
   logic [PIN_W-1:0] s0_r, s1_r, s2_r, lvl_r;
   logic [PIN_W-1:0] s0_nxt, s1_nxt, s2_nxt, lvl_nxt;
   logic [PIN_W-1:0] rise, fall;

   always_comb begin
      s0_nxt  = {i_req, i_ack, i_rd, i_wr};
      s1_nxt  = s0_r;
      s2_nxt  = s1_r;
      lvl_nxt = (s1_r & s2_r) | (lvl_r & (s1_r | s2_r));
      rise    = s1_r & s2_r & ~lvl_r;
      fall    = ~s1_r & ~s2_r & lvl_r;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s0_r  <= '0;
         s1_r  <= '0;
         s2_r  <= '0;
         lvl_r <= '0;
      end else begin
         s0_r  <= s0_nxt;
         s1_r  <= s1_nxt;
         s2_r  <= s2_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   // Address and data are held stable by the bus while the strobe is
   // active, so they are sampled directly when the filtered strobe rises
   logic       wr_ev, rd_ev, ack_rise, ack_fall, cmd_ev;
   logic [7:0] req_lvl;
   logic [2:0] cmd, lvl;

   assign wr_ev    = rise[0] & i_cs;
   assign rd_ev    = rise[1] & i_cs;
   assign ack_rise = rise[2];
   assign ack_fall = fall[2];
   assign req_lvl  = lvl_r[10:3];
   assign cmd      = i_data[CMD_MSB:CMD_LSB];
   assign lvl      = i_data[LEVEL_MSB:0];
   assign cmd_ev   = wr_ev & (i_a0 == EVEN_A0) & ~i_data[INIT_SEL_BIT]
                     & ~i_data[WORD3_SEL_BIT];

   logic [7:0]     mask_r, isr_r, mask_nxt, isr_nxt;
   logic [2:0]     low_r, low_nxt;
   logic [4:0]     vec_r, vec_nxt;
   logic           nest_r, auto_end_r, rot_auto_r, single_r;
   logic           nest_nxt, auto_end_nxt, rot_auto_nxt, single_nxt;
   init_state_type state_r, state_nxt;
   ack_state_type  ack_r, ack_nxt;
   logic [7:0]     data_r, data_nxt, vector_r, vector_nxt;
   logic           int_r, int_nxt;

   logic [7:0] pending;
   logic [2:0] req_ch, isr_ch;
   logic       req_any, isr_any, grant;

   // A masked channel simply drops out; its in-service bit still gates
   assign pending = req_lvl & ~mask_r
                    & (nest_r ? 8'hFF : ~isr_r);

   prio_pick u_req_pick (
      .i_bits (pending),
      .i_low  (low_r),
      .o_ch   (req_ch),
      .o_any  (req_any)
   );

   prio_pick u_isr_pick (
      .i_bits (isr_r),
      .i_low  (low_r),
      .o_ch   (isr_ch),
      .o_any  (isr_any)
   );

   // Equal level passes only with nesting on, fixed or rotated order alike
   assign grant = req_any & (~isr_any
                  | (rank_of(req_ch, low_r) < rank_of(isr_ch, low_r))
                  | (nest_r & (req_ch == isr_ch)));

   always_comb begin
      mask_nxt     = mask_r;
      isr_nxt      = isr_r;
      low_nxt      = low_r;
      vec_nxt      = vec_r;
      nest_nxt     = nest_r;
      auto_end_nxt = auto_end_r;
      rot_auto_nxt = rot_auto_r;
      single_nxt   = single_r;
      state_nxt    = state_r;
      ack_nxt      = ack_r;
      data_nxt     = data_r;
      vector_nxt   = vector_r;
      int_nxt      = grant;
      if (wr_ev && i_a0 == ODD_A0) begin
         unique case (state_r)
            ST_OPER: mask_nxt = i_data;
            ST_TWO: begin
               vec_nxt   = i_data[7:VEC_LSB];
               state_nxt = single_r ? ST_FOUR : ST_THREE;
            end
            ST_THREE: state_nxt = ST_FOUR;
            ST_FOUR: begin
               nest_nxt     = i_data[NEST_BIT];
               auto_end_nxt = i_data[AUTO_END_BIT];
               state_nxt    = ST_OPER;
            end
         endcase
      end else if (wr_ev && i_data[INIT_SEL_BIT]) begin
         mask_nxt     = MASK_RESET;
         low_nxt      = LOW_RESET;
         rot_auto_nxt = 1'b0;
         single_nxt   = i_data[SINGLE_BIT];
         state_nxt    = ST_TWO;
      end else if (wr_ev) begin
         state_nxt = ST_OPER;
      end
      if (cmd_ev) begin
         unique case (cmd)
            CMD_CLR_ROT_AUTO: rot_auto_nxt = 1'b0;
            CMD_NONSPEC_EOI: begin
               if (isr_any) isr_nxt[isr_ch] = 1'b0;
            end
            CMD_NOP: ;
            CMD_SPEC_EOI: isr_nxt[lvl] = 1'b0;
            CMD_SET_ROT_AUTO: rot_auto_nxt = 1'b1;
            CMD_ROT_NONSPEC: begin
               if (isr_any) begin
                  isr_nxt[isr_ch] = 1'b0;
                  low_nxt         = isr_ch;
               end
            end
            CMD_SET_PRIO: low_nxt = lvl;
            CMD_ROT_SPEC: begin
               isr_nxt[lvl] = 1'b0;
               low_nxt      = lvl;
            end
         endcase
      end
      // Acknowledge work comes last so a new service bit beats a clear
      unique case (ack_r)
         ACK_IDLE: begin
            if (ack_rise) begin
               ack_nxt = ACK_FIRST;
               if (grant) isr_nxt[req_ch] = 1'b1;
               vector_nxt = {vec_r, grant ? req_ch : SPURIOUS_CH};
            end
         end
         ACK_FIRST: if (ack_rise) ack_nxt = ACK_SECOND;
         ACK_SECOND: begin
            if (ack_fall) begin
               ack_nxt = ACK_IDLE;
               if (auto_end_r && isr_any) begin
                  isr_nxt[isr_ch] = 1'b0;
                  if (rot_auto_r) low_nxt = isr_ch;
               end
            end
         end
         default: ack_nxt = ACK_IDLE;
      endcase
      if (rd_ev) data_nxt = (i_a0 == ODD_A0) ? mask_r : isr_r;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mask_r     <= MASK_RESET;
         isr_r      <= ISR_RESET;
         low_r      <= LOW_RESET;
         vec_r      <= VEC_RESET;
         nest_r     <= 1'b0;
         auto_end_r <= 1'b0;
         rot_auto_r <= 1'b0;
         single_r   <= 1'b0;
         state_r    <= ST_OPER;
         ack_r      <= ACK_IDLE;
         data_r     <= DATA_RESET;
         vector_r   <= DATA_RESET;
         int_r      <= 1'b0;
      end else begin
         mask_r     <= mask_nxt;
         isr_r      <= isr_nxt;
         low_r      <= low_nxt;
         vec_r      <= vec_nxt;
         nest_r     <= nest_nxt;
         auto_end_r <= auto_end_nxt;
         rot_auto_r <= rot_auto_nxt;
         single_r   <= single_nxt;
         state_r    <= state_nxt;
         ack_r      <= ack_nxt;
         data_r     <= data_nxt;
         vector_r   <= vector_nxt;
         int_r      <= int_nxt;
      end
   end

   assign o_data       = data_r;
   assign o_int        = int_r;
   assign o_vector     = vector_r;
   assign o_in_service = isr_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_second_open;
      ack_r == ACK_SECOND && auto_end_r && isr_any;
   endsequence

   sequence s_trailing_edge;
      ack_fall && !cmd_ev;
   endsequence

   a_init_clears_mask: assert property (
      wr_ev && i_a0 == EVEN_A0 && i_data[INIT_SEL_BIT]
      |=> mask_r == MASK_RESET && state_r == ST_TWO)
      else $error("init word one did not clear mask");

   a_mask_write: assert property (
      wr_ev && i_a0 == ODD_A0 && state_r == ST_OPER
      |=> mask_r == $past(i_data))
      else $error("mask write lost in operational mode");

   a_oper_entry: assert property (
      wr_ev && i_a0 == EVEN_A0 && !i_data[INIT_SEL_BIT]
      |=> state_r == ST_OPER)
      else $error("operation word did not enter operational mode");

   a_masked_no_grant: assert property (
      grant |-> !mask_r[req_ch])
      else $error("masked request was granted");

   a_lower_open: assert property (
      isr_r == ISR_RESET && (req_lvl & ~mask_r) != 8'h00
      |-> grant ##1 int_r)
      else $error("unmasked request blocked by mask");

   a_nest_grant: assert property (
      nest_r && req_any && isr_any && req_ch == isr_ch |-> grant)
      else $error("repeat request refused with nesting on");

   a_spec_eoi: assert property (
      cmd_ev && cmd == CMD_SPEC_EOI && !ack_rise |=> !isr_r[$past(lvl)])
      else $error("specific end of service left bit set");

   a_set_prio: assert property (
      cmd_ev && (cmd == CMD_SET_PRIO || cmd == CMD_ROT_SPEC)
      |=> low_r == $past(lvl))
      else $error("lowest channel not moved by command");

   a_auto_eoi: assert property (
      s_second_open ##0 s_trailing_edge
      |=> !isr_r[$past(isr_ch)] ##1 ack_r == ACK_IDLE)
      else $error("automatic end of service missed");

   a_read_mask: assert property (
      rd_ev && i_a0 == ODD_A0 && !wr_ev && !ack_rise
      |=> o_data == $past(mask_r) && mask_r == $past(mask_r))
      else $error("mask read wrong or disturbed");

endmodule
`default_nettype wire

// File: hdl/icw_pkg.sv
// Constants, types and helpers for the interrupt command word decoder
// Function
// - Word four bit 4 allows same-channel nesting
// - Word four bit 1 ends service automatically
// - Odd address mask writes outside initialization
// - Even address, bit 4 clear: operational words
// - Mask bit one blocks same-index request
// - Mask bit leaves lower priorities untouched
// - Init word one clears all mask bits
// - Command bits 7-5, codes 000 to 011
// - Command bits 7-5, codes 100 to 111
// - Bits 2-0 name channel for specific commands
// - Even address, bit 4 set: init word one
package icw_pkg;

   localparam logic [7:0] EOI_PRIORITY_COMMAND_OFFSET = 8'h20;
   localparam logic [7:0] INIT_WORD_FOUR_OFFSET       = 8'h21;
   localparam logic [7:0] REQUEST_MASK_OFFSET         = 8'h21;
   localparam logic       EVEN_A0 = EOI_PRIORITY_COMMAND_OFFSET[0];
   localparam logic       ODD_A0  = REQUEST_MASK_OFFSET[0];

   localparam int INIT_SEL_BIT  = 4;
   localparam int WORD3_SEL_BIT = 3;
   localparam int SINGLE_BIT    = 1;
   localparam int NEST_BIT      = 4;
   localparam int AUTO_END_BIT  = 1;
   localparam int CMD_MSB       = 7;
   localparam int CMD_LSB       = 5;
   localparam int LEVEL_MSB     = 2;
   localparam int VEC_LSB       = 3;

   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [7:0] ISR_RESET   = 8'h00;
   localparam logic [2:0] LOW_RESET   = 3'h7;
   localparam logic [4:0] VEC_RESET   = 5'h00;
   localparam logic [7:0] DATA_RESET  = 8'h00;
   localparam logic [2:0] SPURIOUS_CH = 3'h7;

   localparam logic [2:0] CMD_CLR_ROT_AUTO = 3'h0;
   localparam logic [2:0] CMD_NONSPEC_EOI  = 3'h1;
   localparam logic [2:0] CMD_NOP          = 3'h2;
   localparam logic [2:0] CMD_SPEC_EOI     = 3'h3;
   localparam logic [2:0] CMD_SET_ROT_AUTO = 3'h4;
   localparam logic [2:0] CMD_ROT_NONSPEC  = 3'h5;
   localparam logic [2:0] CMD_SET_PRIO     = 3'h6;
   localparam logic [2:0] CMD_ROT_SPEC     = 3'h7;

   typedef enum logic [1:0] {
      ST_OPER,
      ST_TWO,
      ST_THREE,
      ST_FOUR
   } init_state_type;

   typedef enum logic [1:0] {
      ACK_IDLE,
      ACK_FIRST,
      ACK_SECOND
   } ack_state_type;

   // Rank 0 is the highest priority: the channel just after the lowest
   function automatic logic [2:0] rank_of(input logic [2:0] ch,
                                          input logic [2:0] low);
      rank_of = 3'(ch - low - 3'h1);
   endfunction

endpackage

// File: hdl/prio_pick.sv
// Picks the highest-priority set bit under a rotating lowest channel
`timescale 1ns/1ps
`default_nettype none
module prio_pick
   import icw_pkg::*;
(
   input  wire logic [7:0] i_bits,
   input  wire logic [2:0] i_low,
   output logic      [2:0] o_ch,
   output logic            o_any
);

   always_comb begin
      o_ch  = SPURIOUS_CH;
      o_any = 1'b0;
      // Walk from rank 7 down to rank 0 so the best candidate wins last
      for (int k = 7; k >= 0; k--) begin
         if (i_bits[3'(i_low + 3'(k) + 3'h1)]) begin
            o_ch  = 3'(i_low + 3'(k) + 3'h1);
            o_any = 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// File: verif/host_cpu_model.sv
// Host processor model: register port cycles and acknowledge pairs
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_cs,
   output logic            o_a0,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_data,
   output logic            o_ack
);
   initial begin
      o_cs = 1'b0;
      o_a0 = 1'b0;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_data = 8'h00;
      o_ack = 1'b0;
   end

   // Write and acknowledge strobes stay 4 clocks, read strobes 5: the pins pass a 3-stage synchronizer
   task automatic hold(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic wr(input logic a0, input logic [7:0] d);
      @(posedge i_clk);
      o_cs <= 1'b1;
      o_a0 <= a0;
      o_data <= d;
      o_wr <= 1'b1;
      hold(4);
      o_wr <= 1'b0;
      o_cs <= 1'b0;
      // Released bus must not keep the last value
      o_data <= ~d;
      hold(4);
   endtask

   task automatic rd(input logic a0, output logic [7:0] q);
      @(posedge i_clk);
      o_cs <= 1'b1;
      o_a0 <= a0;
      o_rd <= 1'b1;
      hold(5);
      q = i_rdata;
      o_rd <= 1'b0;
      o_cs <= 1'b0;
      hold(4);
   endtask

   // Two pulses; the wait after the second covers the trailing edge
   task automatic ack_pair;
      repeat (2) begin
         @(posedge i_clk);
         o_ack <= 1'b1;
         hold(4);
         o_ack <= 1'b0;
         hold(3);
      end
      hold(3);
   endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the command word decoder
`timescale 1ns/1ps
`default_nettype none
module testbench
   import icw_pkg::*;
;
   logic       i_clk;
   logic       i_rst;
   logic [7:0] req;
   logic       cs;
   logic       a0;
   logic       wr;
   logic       rd;
   logic       ack;
   logic       int_out;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] vec;
   logic [7:0] in_service_register;
   logic [7:0] q;
   int         fails = 0;
   int         check_count = 0;
   int         cycles = 0;

   initial i_clk = 1'b0;
   always #12.5 i_clk = ~i_clk;

   host_cpu_model u_host_cpu_model (.i_clk(i_clk), .i_rdata(rdata),
      .o_cs(cs), .o_a0(a0), .o_wr(wr), .o_rd(rd), .o_data(wdata),
      .o_ack(ack));

   icw_ctrl u_icw_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_cs(cs),
      .i_a0(a0), .i_wr(wr), .i_rd(rd), .i_data(wdata), .i_ack(ack),
      .i_req(req), .o_data(rdata), .o_int(int_out), .o_vector(vec),
      .o_in_service(in_service_register));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         $display("[ERR] %0t timeout", $time);
         report_and_stop;
      end
   end

   task automatic w(input logic a, input logic [7:0] d);
      u_host_cpu_model.wr(a, d);
   endtask

   // Command bits 4-3 always zero so the even port sees a command
   task automatic cmd(input logic [2:0] c, input logic [2:0] l);
      w(1'b0, {c, 2'b00, l});
   endtask

   // Single mode skips word three; vector base 08
   task automatic init4(input logic [7:0] d);
      w(1'b0, 8'h13);
      w(1'b1, 8'h08);
      w(1'b1, d);
   endtask

   task automatic rdc(input logic a, input logic [7:0] exp);
      u_host_cpu_model.rd(a, q);
      check(q, exp);
   endtask

   task automatic ackc(input logic [7:0] v, input logic [7:0] s);
      u_host_cpu_model.ack_pair;
      check(vec, v);
      check(in_service_register, s);
   endtask

   task automatic setreq(input logic [7:0] r);
      @(posedge i_clk);
      req <= r;
      repeat (8) @(posedge i_clk);
   endtask

   initial begin
      i_rst = 1'b1;
      req = 8'h00;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      rdc(1'b1, MASK_RESET);
      init4(8'h00);
      w(1'b1, 8'hA5);
      rdc(1'b1, 8'hA5);
      rdc(1'b1, 8'hA5);
      init4(8'h00);
      rdc(1'b1, 8'h00);
      $display("test mask done");
      w(1'b1, 8'h09);
      setreq(8'h09);
      check({7'h00, int_out}, 8'h00);
      w(1'b1, 8'h01);
      check({7'h00, int_out}, 8'h01);
      ackc(8'h0B, 8'h08);
      check({7'h00, int_out}, 8'h00);
      cmd(CMD_NOP, 3'h3);
      check(in_service_register, 8'h08);
      cmd(CMD_SPEC_EOI, 3'h2);
      check(in_service_register, 8'h08);
      cmd(CMD_SPEC_EOI, 3'h3);
      check(in_service_register, 8'h00);
      ackc(8'h0B, 8'h08);
      cmd(CMD_NONSPEC_EOI, 3'h5);
      check(in_service_register, 8'h00);
      $display("test end of service done");
      w(1'b1, 8'h00);
      cmd(CMD_SET_PRIO, 3'h0);
      ackc(8'h0B, 8'h08);
      cmd(CMD_ROT_SPEC, 3'h3);
      ackc(8'h08, 8'h01);
      cmd(CMD_ROT_NONSPEC, 3'h5);
      ackc(8'h0B, 8'h08);
      cmd(CMD_NONSPEC_EOI, 3'h0);
      w(1'b0, 8'h0B);
      check(in_service_register, 8'h00);
      rdc(1'b1, 8'h00);
      $display("test priority done");
      // Automatic end kept off nested slaves; this one is not nested
      init4(8'h02);
      cmd(CMD_SET_ROT_AUTO, 3'h0);
      ackc(8'h08, 8'h00);
      ackc(8'h0B, 8'h00);
      cmd(CMD_CLR_ROT_AUTO, 3'h0);
      ackc(8'h08, 8'h00);
      ackc(8'h08, 8'h00);
      $display("test automatic end done");
      setreq(8'h08);
      init4(8'h10);
      ackc(8'h0B, 8'h08);
      check({7'h00, int_out}, 8'h01);
      ackc(8'h0B, 8'h08);
      rdc(1'b0, 8'h08);
      cmd(CMD_NONSPEC_EOI, 3'h0);
      check(in_service_register, 8'h00);
      $display("test nesting done");
      report_and_stop;
   end
endmodule
`default_nettype wire
